// ===== core/dch_pkg.sv
// Package for the processor side of the I/O bus transfer channel handshake.
// Assumes a single 50 MHz clock; all bus pins sampled synchronously.
package dch_pkg;
   localparam int unsigned CLK_PERIOD_NS   = 20;
   localparam int unsigned DATA_W          = 16;
   localparam int unsigned FIFO_DEPTH      = 32;
   // Minimum pulse widths, in ns, and their cycle counts (rounded up)
   localparam int unsigned REQ_ENB_NS      = 75;
   localparam int unsigned ACK_NS          = 300;
   localparam int unsigned IN_STB_NS       = 350;
   localparam int unsigned OUT_STB_NS      = 100;
   localparam int unsigned RESET_NS        = 500;
   localparam int unsigned REQ_ENB_CYC = (REQ_ENB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned ACK_CYC     = (ACK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned IN_STB_CYC  = (IN_STB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned OUT_STB_CYC = (OUT_STB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned RESET_CYC   = (RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Request enable repeats at this period (below 5 MHz)
   localparam int unsigned REQ_ENB_PERIOD_CYC = 12;
   localparam int unsigned CNT_W = 5;
   // Direction line values during acknowledge
   localparam logic DIR_OUTPUT = 1'b0;
   localparam logic DIR_INPUT  = 1'b1;
   typedef enum logic [2:0] {
      ST_IDLE, ST_ACK, ST_INPUT, ST_OUTPUT, ST_RESET
   } dch_state_t;
endpackage

// ===== core/dch_fifo.sv
// Synchronous FIFO, flip-flop storage, valid/ready on both sides.
// Assumes one clock and synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module dch_fifo #(
   parameter int unsigned WIDTH = 16,
   parameter int unsigned DEPTH = 32
) (
   input  wire logic             ref_clk,
   input  wire logic             srst,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_q;
   logic [AW-1:0]    rd_q;
   logic [AW:0]      cnt_q;
   logic             push;
   logic             pop;

   assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rd_q];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule // dch_fifo
`default_nettype wire

// ===== core/dch_channel.sv
// Processor end of the transfer channel: request enable, acknowledge, strobes, I/O reset.
// Assumes bus pins synchronous to ref_clk; the winning controller answers during acknowledge.
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - The processor pulses request enable low to open the window for requests.
// - The processor asserts acknowledge low at the start of each granted transfer cycle.
// - For input the processor raises the input strobe after the direction is chosen.
// - For output the processor drives the word and raises the output strobe.
// - The processor asserts I/O reset on the reset instruction in ST_IDLE only, and on system reset.
module dch_channel (
   input  wire logic                         ref_clk,
   input  wire logic                         srst,
   input  wire logic                         reset_io_cmd,
   input  wire logic                         xfer_request_n,
   input  wire logic                         xfer_direction_n,
   input  wire logic [dch_pkg::DATA_W-1:0]   data_in,
   output logic      [dch_pkg::DATA_W-1:0]   data_out,
   output logic                              data_oe,
   output logic                              request_enable_n,
   output logic                              xfer_acknowledge_n,
   output logic                              xfer_input_strobe,
   output logic                              xfer_output_strobe,
   output logic                              bus_reset_all,
   output logic      [dch_pkg::DATA_W-1:0]   xfer_address,
   output logic                              addr_valid,
   input  wire logic [dch_pkg::DATA_W-1:0]   tx_data,
   input  wire logic                         tx_valid,
   output logic                              tx_ready,
   output logic      [dch_pkg::DATA_W-1:0]   rx_data,
   output logic                              rx_valid,
   input  wire logic                         rx_ready
);
   import dch_pkg::*;

   dch_state_t       state_q;
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] enb_cnt_q;
   logic             req_seen_q;
   logic             push_q;
   logic [DATA_W-1:0] push_data_q;
   logic             rx_in_ready;
   logic             rx_fifo_valid;
   logic [DATA_W-1:0] rx_fifo_data;
   logic             tx_fifo_valid;
   logic [DATA_W-1:0] tx_fifo_data;
   logic             tx_pop;
   logic             rx_pop;

   function automatic logic [CNT_W-1:0] cyc(input int unsigned n);
      return CNT_W'(n - 1);
   endfunction

   // Request enable pulse; held off during reset so requests stay synchronised
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         enb_cnt_q        <= '0;
         request_enable_n <= 1'b1;
      end else begin
         enb_cnt_q <= (enb_cnt_q == cyc(REQ_ENB_PERIOD_CYC)) ? '0 : enb_cnt_q + 1'b1;
         request_enable_n <= !(enb_cnt_q < CNT_W'(REQ_ENB_CYC));
      end
   end

   // Request sampled only at the close of the enable pulse
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         req_seen_q <= 1'b0;
      end else if (state_q == ST_ACK) begin
         req_seen_q <= 1'b0;
      end else if (enb_cnt_q == CNT_W'(REQ_ENB_CYC)) begin
         req_seen_q <= !xfer_request_n;
      end
   end

   // Word buffer toward the processor side is gated by rx FIFO room
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         state_q            <= ST_RESET;
         cnt_q              <= cyc(RESET_CYC);
         xfer_acknowledge_n <= 1'b1;
         xfer_input_strobe  <= 1'b0;
         xfer_output_strobe <= 1'b0;
         bus_reset_all      <= 1'b1;
         data_oe            <= 1'b0;
         data_out           <= '0;
         xfer_address       <= '0;
         addr_valid         <= 1'b0;
         push_q             <= 1'b0;
         push_data_q        <= '0;
      end else begin
         push_q     <= 1'b0;
         addr_valid <= 1'b0;
         if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
         end
         case (state_q)
            ST_IDLE: begin
               if (reset_io_cmd) begin
                  state_q       <= ST_RESET;
                  cnt_q         <= cyc(RESET_CYC);
                  bus_reset_all <= 1'b1;
               end else if (req_seen_q && rx_in_ready && tx_fifo_valid) begin
                  state_q            <= ST_ACK;
                  cnt_q              <= cyc(ACK_CYC);
                  xfer_acknowledge_n <= 1'b0;
               end
            end
            ST_ACK: begin
               if (cnt_q == '0) begin
                  xfer_acknowledge_n <= 1'b1;
                  xfer_address       <= data_in;
                  addr_valid         <= 1'b1;
                  if (xfer_direction_n == DIR_INPUT) begin
                     state_q           <= ST_INPUT;
                     cnt_q             <= cyc(IN_STB_CYC);
                     xfer_input_strobe <= 1'b1;
                  end else begin
                     state_q            <= ST_OUTPUT;
                     cnt_q              <= cyc(OUT_STB_CYC);
                     data_out           <= tx_fifo_data;
                     data_oe            <= 1'b1;
                     xfer_output_strobe <= 1'b1;
                  end
               end
            end
            ST_INPUT: begin
               if (cnt_q == '0) begin
                  xfer_input_strobe <= 1'b0;
                  push_q            <= 1'b1;
                  push_data_q       <= data_in;
                  state_q           <= ST_IDLE;
               end
            end
            ST_OUTPUT: begin
               if (cnt_q == '0) begin
                  xfer_output_strobe <= 1'b0;
                  data_oe            <= 1'b0;
                  state_q            <= ST_IDLE;
               end
            end
            ST_RESET: begin
               if (cnt_q == '0) begin
                  bus_reset_all <= 1'b0;
                  state_q       <= ST_IDLE;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Pop the outgoing word at the end of an output strobe
   assign tx_pop = (state_q == ST_OUTPUT) && (cnt_q == '0);

   dch_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
      .ref_clk   (ref_clk),
      .srst      (srst),
      .in_data   (tx_data),
      .in_valid  (tx_valid),
      .in_ready  (tx_ready),
      .out_data  (tx_fifo_data),
      .out_valid (tx_fifo_valid),
      .out_ready (tx_pop)
   );

   dch_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
      .ref_clk   (ref_clk),
      .srst      (srst),
      .in_data   (push_data_q),
      .in_valid  (push_q),
      .in_ready  (rx_in_ready),
      .out_data  (rx_fifo_data),
      .out_valid (rx_fifo_valid),
      .out_ready (rx_pop)
   );

   // Output stage holds one word; refills only when empty or being taken,
   // so a word is never shown twice to the consumer
   assign rx_pop = rx_fifo_valid && (!rx_valid || rx_ready);

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         rx_valid <= 1'b0;
         rx_data  <= '0;
      end else if (rx_pop) begin
         rx_valid <= 1'b1;
         rx_data  <= rx_fifo_data;
      end else if (rx_ready) begin
         rx_valid <= 1'b0;
      end
   end

   a_ack_width: assert property (@(posedge ref_clk) disable iff (srst)
      $fell(xfer_acknowledge_n) |-> !xfer_acknowledge_n [*8] ##1 !xfer_acknowledge_n [*7])
      else $error("acknowledge shorter than minimum");
   a_in_strobe: assert property (@(posedge ref_clk) disable iff (srst)
      $rose(xfer_input_strobe) |->
         xfer_input_strobe [*8] ##1 xfer_input_strobe [*8] ##1 xfer_input_strobe [*2])
      else $error("input strobe too short");
   a_out_drive: assert property (@(posedge ref_clk) disable iff (srst)
      xfer_output_strobe |-> data_oe)
      else $error("output strobe without data drive");
   a_strobe_excl: assert property (@(posedge ref_clk) disable iff (srst)
      !(xfer_input_strobe && xfer_output_strobe) && !(xfer_input_strobe && !xfer_acknowledge_n))
      else $error("strobes overlap");
   a_ack_then_stb: assert property (@(posedge ref_clk) disable iff (srst)
      $rose(xfer_acknowledge_n) && !bus_reset_all |-> xfer_input_strobe || xfer_output_strobe)
      else $error("no strobe after acknowledge");
   a_enb_width: assert property (@(posedge ref_clk) disable iff (srst)
      $fell(request_enable_n) |-> !request_enable_n [*4] ##1 request_enable_n)
      else $error("request enable pulse width wrong");
   a_reset_width: assert property (@(posedge ref_clk) disable iff (srst)
      $rose(bus_reset_all) |->
         bus_reset_all [*8] ##1 bus_reset_all [*8] ##1 bus_reset_all [*8] ##1 bus_reset_all)
      else $error("io reset too short");
   a_reset_quiet: assert property (@(posedge ref_clk) disable iff (srst)
      bus_reset_all |-> xfer_acknowledge_n && !xfer_output_strobe)
      else $error("transfer during io reset");
endmodule // dch_channel
`default_nettype wire

// ===== test/dch_ctl_model.sv
// Behavioural controller on the far side of the transfer channel.
// Assumes one clock; the channel samples and drives the bus on ref_clk.
`timescale 1ns/10ps
`default_nettype none
module dch_ctl_model (
   input  wire logic                       ref_clk,
   input  wire logic                       start,
   input  wire logic                       dir,
   input  wire logic [dch_pkg::DATA_W-1:0] addr,
   input  wire logic [dch_pkg::DATA_W-1:0] word,
   input  wire logic                       pri_in,
   output logic                            pri_out,
   input  wire logic                       request_enable_n,
   input  wire logic                       xfer_acknowledge_n,
   input  wire logic                       xfer_input_strobe,
   input  wire logic                       xfer_output_strobe,
   input  wire logic                       bus_reset_all,
   input  wire logic [dch_pkg::DATA_W-1:0] data_out,
   output logic                            xfer_request_n,
   output logic                            xfer_direction_n,
   output logic      [dch_pkg::DATA_W-1:0] data_in,
   output logic      [dch_pkg::DATA_W-1:0] got_word
);
   import dch_pkg::*;
   logic              pend_q, en_q, stb_q, win, busy;
   logic [DATA_W-1:0] last_q;
   assign win = pend_q & pri_in & ~xfer_acknowledge_n;
   assign pri_out = pri_in & ~pend_q;
   // Released data lines toggle and the released direction line shows ~dir, so a stale value never looks driven
   assign data_in = win ? addr : (xfer_input_strobe & pend_q) ? word : ~last_q;
   assign xfer_direction_n = win ? dir : ~dir;
   // Withdraw while in a transfer, so a window overlapping it sees no request
   assign busy = ~xfer_acknowledge_n | xfer_input_strobe | xfer_output_strobe | stb_q;
   always_ff @(posedge ref_clk) begin
      en_q <= request_enable_n;
      stb_q <= xfer_input_strobe | xfer_output_strobe;
      last_q <= data_in;
      if (bus_reset_all) begin
         pend_q <= 1'b0;
         xfer_request_n <= 1'b1;
      end else begin
         if (start) pend_q <= 1'b1;
         else if (stb_q & ~(xfer_input_strobe | xfer_output_strobe)) pend_q <= 1'b0;
         if (en_q & ~request_enable_n) xfer_request_n <= ~(pend_q & ~busy);
      end
   end
   always_ff @(posedge ref_clk) begin
      if (xfer_output_strobe & pend_q) got_word <= data_out;
   end
endmodule // dch_ctl_model
`default_nettype wire

// ===== test/dch_channel_tb.sv
// Self-checking bench for the transfer channel with one controller model on the bus.
// Assumes widths and pulse counts come from dch_pkg.
`timescale 1ns/10ps
`default_nettype none
module dch_channel_tb;
   import dch_pkg::*;
   logic              ref_clk = 1'b0, srst = 1'b1, cmd = 1'b0, start = 1'b0, dir = 1'b0;
   logic              tx_valid = 1'b0, req_n, dir_n, oe, en_n, ack_n, istb, ostb, rst_all;
   logic              av, tx_ready, rx_valid, pri_out;
   logic [DATA_W-1:0] din, dout, xa, rx_data, got;
   logic [DATA_W-1:0] addr = 16'h0000, word = 16'h0000, tx_data = 16'h0000;
   int                miscompares = 0, samples_checked = 0, cyc = 0;
   // Codes naming the bus line that run_len watches
   localparam int     SEL_ACK = 0, SEL_ISTB = 1, SEL_OSTB = 2, SEL_RST = 3, SEL_ENB = 4;
   dch_channel i_dut (.ref_clk(ref_clk), .srst(srst), .reset_io_cmd(cmd),
      .xfer_request_n(req_n), .xfer_direction_n(dir_n), .data_in(din), .data_out(dout),
      .data_oe(oe), .request_enable_n(en_n), .xfer_acknowledge_n(ack_n),
      .xfer_input_strobe(istb), .xfer_output_strobe(ostb), .bus_reset_all(rst_all),
      .xfer_address(xa), .addr_valid(av), .tx_data(tx_data), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(1'b1));
   dch_ctl_model i_ctl (.ref_clk(ref_clk), .start(start), .dir(dir), .addr(addr),
      .word(word), .pri_in(1'b1), .pri_out(pri_out), .request_enable_n(en_n),
      .xfer_acknowledge_n(ack_n), .xfer_input_strobe(istb), .xfer_output_strobe(ostb),
      .bus_reset_all(rst_all), .data_out(dout), .xfer_request_n(req_n),
      .xfer_direction_n(dir_n), .data_in(din), .got_word(got));
   initial begin
      forever #10 ref_clk = ~ref_clk;
   end
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         summarize();
      end
   end
   task automatic cmp(string what, logic [31:0] exp, logic [31:0] seen);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   function automatic logic pick(input int w);
      case (w)
         SEL_ACK:  return ack_n;
         SEL_ISTB: return istb;
         SEL_OSTB: return ostb;
         SEL_RST:  return rst_all;
         default:  return en_n;
      endcase
   endfunction
   // Bounded wait for a level, then its length in cycles
   task automatic run_len(input int w, input logic lvl, output int n);
      int k;
      k = 0;
      n = 0;
      while (pick(w) !== lvl && k < 400) begin
         tick(1);
         k++;
      end
      while (pick(w) === lvl && n < 400) begin
         tick(1);
         n++;
      end
   endtask
   task automatic push(logic [DATA_W-1:0] w);
      int k;
      k = 0;
      tx_data = w;
      tx_valid = 1'b1;
      while (tx_ready !== 1'b1 && k < 50) begin
         tick(1);
         k++;
      end
      tick(1);
      tx_valid = 1'b0;
   endtask
   task automatic xfer(logic d, logic [DATA_W-1:0] a, logic [DATA_W-1:0] w);
      int n;
      dir = d;
      addr = a;
      word = w;
      start = 1'b1;
      tick(1);
      start = 1'b0;
      cmp("priority out while pending", 0, pri_out);
      run_len(SEL_ACK, 1'b0, n);
      cmp("ack cycles", ACK_CYC, n);
      cmp("address valid", 1, av);
      if (d === DIR_INPUT) run_len(SEL_ISTB, 1'b1, n);
      else run_len(SEL_OSTB, 1'b1, n);
      cmp("strobe cycles", (d === DIR_INPUT) ? IN_STB_CYC : OUT_STB_CYC, n);
      cmp("address", a, xa);
      if (d === DIR_OUTPUT) cmp("output word", w, got);
      else begin
         n = 0;
         while (rx_valid !== 1'b1 && n < 50) begin
            tick(1);
            n++;
         end
         cmp("input word", w, rx_data);
      end
   endtask
   task automatic t_reset();
      int n;
      cmp("ack in reset", 1, ack_n);
      cmp("oe in reset", 0, oe);
      cmp("priority idle", 1, pri_out);
      srst = 1'b0;
      run_len(SEL_RST, 1'b1, n);
      cmp("reset cycles", RESET_CYC, n);
      run_len(SEL_ENB, 1'b0, n);
      cmp("enable low", REQ_ENB_CYC, n);
      run_len(SEL_ENB, 1'b1, n);
      cmp("enable high", REQ_ENB_PERIOD_CYC - REQ_ENB_CYC, n);
      $display("test reset done");
   endtask
   // Fill with no request pending, then drain through back-to-back outputs
   task automatic t_fifo();
      int i;
      i = 0;
      tx_valid = 1'b1;
      while (tx_ready === 1'b1 && i < 40) begin
         tx_data = 16'h0100 + 16'(i);
         tick(1);
         i++;
      end
      tx_valid = 1'b0;
      cmp("fifo fill", FIFO_DEPTH, i);
      for (i = 0; i < FIFO_DEPTH; i++) xfer(DIR_OUTPUT, 16'h0200 + 16'(i), 16'h0100 + 16'(i));
      cmp("fifo drained", 1, tx_ready);
      $display("test fifo done");
   endtask
   task automatic t_dirs();
      int n;
      push(16'h0F0F);
      xfer(DIR_INPUT, 16'h7FFE, 16'hA5C3);
      push(16'h0F0F);
      xfer(DIR_OUTPUT, 16'h8001, 16'h0F0F);
      cmd = 1'b1;
      tick(1);
      cmd = 1'b0;
      run_len(SEL_RST, 1'b1, n);
      cmp("io reset cycles", RESET_CYC, n);
      cmp("request after io reset", 1, req_n);
      $display("test directions done");
   endtask
   initial begin
      tick(6);
      t_reset();
      t_fifo();
      t_dirs();
      summarize();
   end
endmodule // dch_channel_tb
`default_nettype wire
